// file: design/ubdsr_top.sv
// Baud rate generator and oversampling receiver with APB registers
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module ubdsr_top
  import ubdsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] div_low_q;
  logic [3:0] div_high_q;
  logic dss_q;
  logic overrun_q;
  logic frame_err_q;
  logic [11:0] baud_divisor_value;
  logic [11:0] rate_cnt_q;
  logic tick_q;
  logic rx_meta_q;
  logic rx_sync_q;
  ubdsr_state_type state_q;
  logic [4:0] samp_q;
  logic [2:0] bit_idx_q;
  logic [1:0] votes_q;
  logic [7:0] shift_q;
  logic vote_maj;
  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [4:0] vote_last;
  logic vote_now;
  logic char_done;
  ubdsr_rx_word_type hold_q;
  logic hold_valid_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  ubdsr_rx_word_type fifo_out;
  logic apb_acc;
  logic apb_done;
  logic wr_div_low;
  logic wr_div_high;
  logic wr_ctrl;
  logic rd_data;
  logic addr_hit;

  ////////////////////////////////////////////////////////////////////
  // APB slave

  // Access phase and its completing edge
  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready_q;

  // Address decode
  assign wr_div_low = apb_done & pwrite &
    (paddr == ubdsr_byte_addr(IDX_DIV_LOW));
  assign wr_div_high = apb_done & pwrite &
    (paddr == ubdsr_byte_addr(IDX_DIV_HIGH));
  assign wr_ctrl = apb_done & pwrite &
    (paddr == ubdsr_byte_addr(IDX_CTRL_A));
  assign rd_data = apb_done & ~pwrite &
    (paddr == ubdsr_byte_addr(IDX_RX_DATA));
  assign addr_hit = (paddr == ubdsr_byte_addr(IDX_DIV_LOW)) |
    (paddr == ubdsr_byte_addr(IDX_DIV_HIGH)) |
    (paddr == ubdsr_byte_addr(IDX_CTRL_A)) |
    (paddr == ubdsr_byte_addr(IDX_RX_DATA));

  // One wait state: ready rises one cycle into the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_acc & ~pready_q;
    end
  end

  // Error answer for any unmapped address, paired with ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= apb_acc & ~pready_q & ~addr_hit;
    end
  end

  // Read data latched in the wait cycle, held until the next read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (apb_acc && !pready_q && !pwrite) begin
      prdata_q <= '0;
      if (paddr == ubdsr_byte_addr(IDX_DIV_LOW)) begin
        prdata_q[7:0] <= div_low_q;
      end else if (paddr == ubdsr_byte_addr(IDX_DIV_HIGH)) begin
        // Upper nibble is read-only zero
        prdata_q[3:0] <= div_high_q;
      end else if (paddr == ubdsr_byte_addr(IDX_CTRL_A)) begin
        prdata_q[CTRL_AVAIL_BIT] <= fifo_out_valid;
        prdata_q[CTRL_BUSY_BIT] <= (state_q != ST_IDLE);
        prdata_q[CTRL_FERR_BIT] <= frame_err_q;
        prdata_q[CTRL_OVR_BIT] <= overrun_q;
        prdata_q[CTRL_DSS_BIT] <= dss_q;
      end else if (paddr == ubdsr_byte_addr(IDX_RX_DATA)) begin
        // Empty buffer reads as zero
        if (fifo_out_valid) begin
          prdata_q[7:0] <= fifo_out.data;
          prdata_q[RXD_FERR_BIT] <= fifo_out.frame_err;
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Divisor halves; a new value is used at the next reload
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_low_q <= DIV_LOW_RST;
      div_high_q <= DIV_HIGH_RST;
    end else begin
      if (wr_div_low) begin
        div_low_q <= pwdata[7:0];
      end
      if (wr_div_high) begin
        div_high_q <= pwdata[3:0];
      end
    end
  end

  // Double-speed select in the control and status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dss_q <= 1'b0;
    end else if (wr_ctrl) begin
      dss_q <= pwdata[CTRL_DSS_BIT];
    end
  end

  // Single divisor for both modes
  assign baud_divisor_value = {div_high_q, div_low_q};

  ////////////////////////////////////////////////////////////////////
  // Status flags, write one to clear; a set in the same cycle wins

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (char_done && hold_valid_q && !fifo_in_ready) begin
        overrun_q <= 1'b1;
      end else if (wr_ctrl && pwdata[CTRL_OVR_BIT]) begin
        overrun_q <= 1'b0;
      end
      if (char_done && !vote_maj) begin
        frame_err_q <= 1'b1;
      end else if (wr_ctrl && pwdata[CTRL_FERR_BIT]) begin
        frame_err_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Rate generator

  // Down-counter reloads from the divisor: one tick every
  // divisor+1 clocks, so 8 or 16 ticks set the bit rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (rate_cnt_q == '0) begin
      rate_cnt_q <= baud_divisor_value;
      tick_q <= 1'b1;
    end else begin
      rate_cnt_q <= rate_cnt_q - 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Ticks per bit and voting window by mode
  assign spb = dss_q ? SPB_DOUBLE : SPB_NORMAL;
  assign vote_first = dss_q ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  assign vote_last = vote_first + 5'h02;

  ////////////////////////////////////////////////////////////////////
  // Receive line synchroniser; only the second stage is used

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd;
      rx_sync_q <= rx_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver

  // Two earlier votes plus the live sample decide the bit
  assign vote_maj = (votes_q[0] & votes_q[1]) |
    (votes_q[0] & rx_sync_q) | (votes_q[1] & rx_sync_q);
  assign vote_now = tick_q && (state_q != ST_IDLE) &&
    (samp_q == vote_last);
  assign char_done = vote_now && (state_q == ST_STOP);

  // Collect the first two samples of the voting window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      votes_q <= 2'b11;
    end else if (tick_q && samp_q == vote_first) begin
      votes_q[0] <= rx_sync_q;
    end else if (tick_q && samp_q == vote_first + 5'h01) begin
      votes_q[1] <= rx_sync_q;
    end
  end

  // Frame sequencer. The trade-off: leaving at the stop vote
  // lets a back-to-back start edge be seen up to 6 of 16 samples (2 of 8 at double speed) early.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      samp_q <= SAMP_FIRST;
      bit_idx_q <= '0;
    end else if (tick_q) begin
      unique case (state_q)
        ST_IDLE: begin
          if (!rx_sync_q) begin
            // The detecting tick is sample 1, so the next one is 2
            state_q <= ST_START;
            samp_q <= SAMP_FIRST + 5'h01;
          end
        end
        ST_START: begin
          samp_q <= (samp_q >= spb) ? SAMP_FIRST : samp_q + 5'h01;
          if (samp_q == vote_last) begin
            if (vote_maj) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_DATA;
              bit_idx_q <= '0;
            end
          end
        end
        ST_DATA: begin
          samp_q <= (samp_q >= spb) ? SAMP_FIRST : samp_q + 5'h01;
          if (samp_q == vote_last) begin
            if (bit_idx_q == LAST_DATA_BIT) begin
              state_q <= ST_STOP;
            end else begin
              bit_idx_q <= bit_idx_q + 3'h1;
            end
          end
        end
        ST_STOP: begin
          samp_q <= (samp_q >= spb) ? SAMP_FIRST : samp_q + 5'h01;
          if (samp_q == vote_last) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Data bits enter LSB first as soon as they are voted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (vote_now && state_q == ST_DATA) begin
      shift_q <= {vote_maj, shift_q[7:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Holding stage in front of the buffer

  // A full buffer stalls the hold; a character finished while the
  // hold is still stuck is dropped and flagged as overrun
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= '0;
      hold_valid_q <= 1'b0;
    end else if (char_done && (!hold_valid_q || fifo_in_ready)) begin
      hold_q.data <= shift_q;
      hold_q.frame_err <= ~vote_maj;
      hold_valid_q <= 1'b1;
    end else if (fifo_in_ready) begin
      hold_valid_q <= 1'b0;
    end
  end

  // Reading the data register pops one word
  assign fifo_pop = rd_data & fifo_out_valid;

  ubdsr_fifo #(
    .WIDTH($bits(ubdsr_rx_word_type)),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(hold_valid_q),
    .in_ready(fifo_in_ready),
    .in_data(hold_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_apb_wait_state: assert property (
    apb_acc && !pready_q |=> pready_q ##1 !pready_q)
    else $error("ready not given after one wait cycle");

  a_div_high_write: assert property (
    wr_div_high |=> baud_divisor_value[11:8] == $past(pwdata[3:0]))
    else $error("high divisor nibble not updated");

  a_tick_reload: assert property (
    tick_q |-> rate_cnt_q == $past(baud_divisor_value))
    else $error("tick without divisor reload");

  a_tick_period: assert property (
    tick_q && baud_divisor_value == 12'h002 &&
    $stable(baud_divisor_value) |=> !tick_q [*2] ##1 tick_q)
    else $error("tick period not divisor plus one");

  a_start_edge: assert property (
    tick_q && state_q == ST_IDLE && !rx_sync_q
    |=> state_q == ST_START && samp_q == SAMP_FIRST + 5'h01)
    else $error("start edge not taken as sample one");

  a_noise_reject: assert property (
    vote_now && state_q == ST_START && vote_maj |=> state_q == ST_IDLE)
    else $error("noise spike accepted as start");

  a_double_window: assert property (
    dss_q && vote_now |-> samp_q == 5'h06)
    else $error("double-speed vote not at sample six");

  a_bit_wrap: assert property (
    tick_q && state_q != ST_IDLE && samp_q == spb
    |=> samp_q == SAMP_FIRST)
    else $error("bit length in samples wrong");

  a_shift_in: assert property (
    vote_now && state_q == ST_DATA
    |=> shift_q == {$past(vote_maj), $past(shift_q[7:1])})
    else $error("voted bit not shifted in");

  a_overrun_flag: assert property (
    char_done && hold_valid_q && !fifo_in_ready |=> overrun_q)
    else $error("overrun not flagged");

endmodule : ubdsr_top

// file: shared/ubdsr_pkg.sv
// Package: constants and types of the baud generator and receiver
// Summary of operation
// - One 12-bit divisor from two registers
// - High nibble from high register, byte from low
// - Double-speed select doubles the bit rate
// - Double speed: 8 samples per bit, not 16
// - Double speed: line sampled at eight times bit rate
// - Idle low sample is start edge, sample 1
// - Two of samples 8,9,10 (4,5,6 at double speed) high rejects start
// - Each bit is majority of samples 8,9,10 (4,5,6 at double speed)
// - Shift each bit in once it is decided
// - Double speed rate is clock/(8*(divisor+1))
// - Normal rate is clock/(16*(divisor+1))
// - Control bit 1 selects division by 8
package ubdsr_pkg;

  // System clock, 20 MHz
  localparam int unsigned CLK_HZ = 20000000;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIV_LOW = 8'h09;
  localparam logic [7:0] IDX_DIV_HIGH = 8'h20;
  localparam logic [7:0] IDX_CTRL_A = 8'h0B;
  localparam logic [7:0] IDX_RX_DATA = 8'h0C;
  localparam int ADDR_W = 12;

  // Values after reset
  localparam logic [7:0] DIV_LOW_RST = 8'h00;
  localparam logic [3:0] DIV_HIGH_RST = 4'h0;

  // Field positions in the control and status register
  localparam int CTRL_DSS_BIT = 1;
  localparam int CTRL_OVR_BIT = 3;
  localparam int CTRL_FERR_BIT = 4;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_AVAIL_BIT = 7;
  // Framing flag of a word in the receive data register
  localparam int RXD_FERR_BIT = 8;

  // Samples per bit and first voting sample per mode
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] SAMP_FIRST = 5'h01;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Receive buffer depth
  localparam int RX_FIFO_DEPTH = 8;

  // Receiver states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } ubdsr_state_type;

  // One received character as it travels through the buffer
  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } ubdsr_rx_word_type;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] ubdsr_byte_addr(
    input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ubdsr_byte_addr

endpackage : ubdsr_pkg

// file: design/ubdsr_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ubdsr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_q != CNT_W'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage, no reset needed on the data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap explicitly so any depth works
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    count_q <= CNT_W'(DEPTH))
    else $error("fifo count above depth");

endmodule : ubdsr_fifo

// file: sim/ubdsr_serial_peer.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/100ps
module ubdsr_serial_peer (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic stop_bit,
  input wire logic [15:0] bit_clks,
  input wire logic [7:0] glitch_clks,
  output logic rxd,
  output logic busy
);
  logic [9:0] frame;

  ////////////////////////////////////////////////////////////////////////
  // One frame or one noise spike per go; line idles high between frames
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        if (glitch_clks != 8'h00) begin
          // Short low pulse that must not pass as a start bit
          rxd <= 1'b0;
          repeat (glitch_clks) @(posedge clk);
        end else begin
          // Start, eight data bits LSB first, stop; bit time set by bench
          frame = {stop_bit, data, 1'b0};
          for (int i = 0; i < 10; i++) begin
            rxd <= frame[i];
            repeat (bit_clks) @(posedge clk);
          end
        end
        rxd <= 1'b1;
        repeat (4) @(posedge clk); // Let the byte reach the buffer
        busy <= 1'b0;
      end
    end
  end
endmodule : ubdsr_serial_peer

// file: sim/testbench.sv
// Testbench: register access and oversampled reception checks
`timescale 1ns/100ps
module testbench
  import ubdsr_pkg::*;
;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic go;
  logic [7:0] tx_byte;
  logic stop_bit;
  logic [15:0] bit_clks;
  logic [7:0] glitch_clks;
  logic busy;
  logic [33:0] exp_q[$];
  logic [7:0] sent_q[$];
  logic [33:0] exp;
  int error_cnt;
  int n_checks;
  // Divisor modes: bit 12 double speed, bits 11:0 divisor
  localparam logic [12:0] MODES [5] = '{13'h1000, 13'h1002, 13'h0001,
                                        13'h0000, 13'h1101};
  // Longest possible run of the old divisor before a reload
  localparam int SETTLE_CLKS = 4100;

  ubdsr_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd));

  ubdsr_serial_peer i_peer (.clk(clk), .go(go), .data(tx_byte),
    .stop_bit(stop_bit), .bit_clks(bit_clks), .glitch_clks(glitch_clks),
    .rxd(rxd), .busy(busy));

  ////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // One APB transfer; request held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [7:0] idx,
                          input logic [31:0] wd, input logic [33:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      $display("FAIL pready exp 1 seen %b", pready);
      error_cnt++;
      stop_test();
    end
  endtask : apb_xfer

  task automatic apb_wr(input logic [7:0] idx, input logic [31:0] wd,
                        input logic err);
    apb_xfer(1'b1, idx, wd, {1'b1, err, 32'h0});
  endtask : apb_wr

  task automatic apb_rd(input logic [7:0] idx, input logic [31:0] ed,
                        input logic err);
    apb_xfer(1'b0, idx, 32'h0, {1'b0, err, ed});
  endtask : apb_rd

  // Divisor halves written separately, then the speed select
  task automatic set_mode(input logic [12:0] md);
    apb_wr(IDX_DIV_LOW, {24'h0, md[7:0]}, 1'b0);
    apb_wr(IDX_DIV_HIGH, {28'h0, md[11:8]}, 1'b0);
    apb_wr(IDX_CTRL_A, {30'h0, md[12], 1'b0}, 1'b0);
    bit_clks <= (md[12] ? 16'h0008 : 16'h0010) * (md[11:0] + 16'h0001);
    // The new divisor loads only when the old count runs out
    repeat (SETTLE_CLKS) @(posedge clk);
  endtask : set_mode

  // Hand one frame to the peer and wait for the line to go idle
  task automatic send(input logic [7:0] b, input logic sb,
                      input logic [7:0] gl);
    int k;
    @(posedge clk);
    go <= 1'b1;
    tx_byte <= b;
    stop_bit <= sb;
    glitch_clks <= gl;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 25000; k++) begin
      @(posedge clk);
      if (!busy) break;
    end
    if (k == 25000) begin
      $display("FAIL peer busy exp 0 seen %b", busy);
      error_cnt++;
      stop_test();
    end
    if (gl == 8'h00) sent_q.push_back(b);
  endtask : send

  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      apb_rd(IDX_RX_DATA, {24'h0, sent_q.pop_front()}, 1'b0);
    end
    sent_q.delete();
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  // Scoreboard: oldest note against each completed transfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      exp = exp_q.pop_front();
      n_checks++;
      // Writes carry no read data, so only the error answer counts
      if (pslverr !== exp[32] ||
          (!exp[33] && prdata !== exp[31:0])) begin
        $display("FAIL apb idx %h exp %h seen %h", paddr[9:2], exp[32:0],
                 {pslverr, prdata});
        error_cnt++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    go = 1'b0;
    tx_byte = 8'h00;
    stop_bit = 1'b1;
    bit_clks = 16'h0008;
    glitch_clks = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(73));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, read-only upper nibble
    apb_rd(IDX_DIV_LOW, 32'h0, 1'b0);
    apb_rd(IDX_DIV_HIGH, 32'h0, 1'b0);
    apb_rd(IDX_CTRL_A, 32'h0, 1'b0);
    apb_rd(IDX_RX_DATA, 32'h0, 1'b0);
    apb_rd(8'h3F, 32'h0, 1'b1);
    apb_wr(8'h3F, 32'hFF, 1'b1);
    apb_wr(IDX_DIV_HIGH, 32'hFF, 1'b0);
    apb_rd(IDX_DIV_HIGH, 32'h0F, 1'b0);
    apb_wr(IDX_DIV_LOW, 32'hA5, 1'b0);
    apb_rd(IDX_DIV_LOW, 32'hA5, 1'b0);
    // Noise spike of three samples, then a real byte
    set_mode(13'h1000);
    send(8'h00, 1'b1, 8'h03);
    apb_rd(IDX_CTRL_A, 32'h02, 1'b0);
    send(8'($urandom), 1'b1, 8'h00);
    drain(1);
    // Zero stop bit: byte kept with flag, sticky flag cleared by one
    send(8'h3C, 1'b0, 8'h00);
    apb_rd(IDX_CTRL_A, 32'h92, 1'b0);
    apb_rd(IDX_RX_DATA, 32'h13C, 1'b0);
    sent_q.delete();
    apb_wr(IDX_CTRL_A, 32'h12, 1'b0);
    apb_rd(IDX_CTRL_A, 32'h02, 1'b0);
    // Overfill the buffer; oldest nine survive (eight buffered, one in the hold), the first eight read in order
    for (int i = 0; i < 11; i++) send(8'($urandom), 1'b1, 8'h00);
    apb_rd(IDX_CTRL_A, 32'h8A, 1'b0);
    drain(8);
    // Reset in mid-run clears everything
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb_rd(IDX_DIV_LOW, 32'h0, 1'b0);
    apb_rd(IDX_CTRL_A, 32'h0, 1'b0);
    // Each rate: two back-to-back bytes at the computed bit time
    for (int m = 0; m < 5; m++) begin
      set_mode(MODES[m]);
      repeat (2) send(8'($urandom), 1'b1, 8'h00);
      drain(2);
    end
    apb_rd(IDX_DIV_HIGH, 32'h01, 1'b0);
    stop_test();
  end
endmodule : testbench
